// ===== rtl/bwn_pkg.sv
// Shared constants and types for the branch-with-idle-cycles unit.
package bwn_pkg;

  // Data path widths.
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned IDLE_IMM_W = 3;
  localparam int unsigned IDLE_CNT_W = 4;
  localparam int unsigned OFF10_W    = 10;
  localparam int unsigned OFF12_W    = 12;
  localparam int unsigned OFF_SHIFT  = 2;
  localparam int unsigned DELAY_W    = 3;

  // Idle cycle limits and the branch shadow.
  localparam logic [IDLE_IMM_W-1:0] MAX_IDLE_IMM  = 3'h5;
  localparam logic [IDLE_CNT_W-1:0] IDLE_EXTRA    = 4'h1;
  localparam logic [IDLE_CNT_W-1:0] IDLE_ZERO     = 4'h0;
  localparam logic [DELAY_W-1:0]    DELAY_SLOTS   = 3'h5;
  localparam logic [DELAY_W-1:0]    DELAY_ZERO    = 3'h0;
  localparam logic [DELAY_W-1:0]    DELAY_LAST    = 3'h1;

  // Reset values of the fetch counter outputs.
  localparam logic [DATA_W-1:0]     COUNTER_RESET = 32'h0000_0000;

  // Decoded branch operation presented at the first execute stage.
  typedef enum logic [1:0] {
    BWN_OP_NONE,
    BWN_OP_IDLE_REG,
    BWN_OP_IDLE_DISP,
    BWN_OP_NONNEG
  } bwn_op_t;

  // Functional unit that carries the instruction.
  typedef enum logic {
    BWN_UNIT_S1,
    BWN_UNIT_S2
  } bwn_unit_t;

endpackage

// ===== rtl/bwn_idle_if.sv
// Interface between the branch control and its idle cycle counter.
`timescale 1ns/1ps
`default_nettype none

interface bwn_idle_if;
  import bwn_pkg::*;

  logic                  load;
  logic [IDLE_CNT_W-1:0] load_count;
  logic                  cut;
  logic                  busy;
  logic [IDLE_CNT_W-1:0] count;

  modport ctrl (
    output load,
    output load_count,
    output cut,
    input  busy,
    input  count
  );

  modport counter (
    input  load,
    input  load_count,
    input  cut,
    output busy,
    output count
  );

endinterface

`default_nettype wire

// ===== rtl/bwn_idle_counter.sv
// Down counter that holds the core idle for the inserted idle cycles.
`timescale 1ns/1ps
`default_nettype none

module bwn_idle_counter
  import bwn_pkg::*;
(
  // Clock and reset.
  input  wire logic    clock,
  input  wire logic    reset,
  input  wire logic    clock_enable,
  // Control from the branch unit.
  bwn_idle_if.counter  idle
);

  logic [IDLE_CNT_W-1:0] count;
  logic [IDLE_CNT_W-1:0] next_count;

  // A load only comes while the counter is idle, so a branch landing in the same cycle
  // has no run left to end; letting the cut win there would lose the new idle run.
  always_comb
  begin
    next_count = count;
    if (idle.load)
    begin
      next_count = idle.load_count;
    end
    else if (idle.cut)
    begin
      next_count = IDLE_ZERO;
    end
    else if (count != IDLE_ZERO)
    begin
      next_count = count - IDLE_EXTRA;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      count <= IDLE_ZERO;
    end
    else if (clock_enable)
    begin
      count <= next_count;
    end
  end

  assign idle.count = count;
  assign idle.busy  = (count != IDLE_ZERO);

endmodule

`default_nettype wire

// ===== rtl/bwn_branch_unit.sv
// Branch execution for the register and displacement idle branches and the nonnegative branch.
`timescale 1ns/1ps
`default_nettype none

module bwn_branch_unit
  import bwn_pkg::*;
(
  // Clock, reset and freeze.
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  clock_enable,
  // Instruction at the first execute stage.
  input  wire logic                  issue_valid,
  input  wire bwn_op_t               issue_op,
  input  wire bwn_unit_t             issue_unit,
  input  wire logic                  predicate_true,
  input  wire logic [DATA_W-1:0]     second_source_operand,
  input  wire logic [DATA_W-1:0]     tested_register,
  input  wire logic [IDLE_IMM_W-1:0] idle_count_immediate,
  input  wire logic [OFF10_W-1:0]    signed_offset_immediate,
  input  wire logic [OFF12_W-1:0]    wide_signed_offset_immediate,
  input  wire logic [DATA_W-1:0]     fetch_packet_base_address,
  // Program fetch counter update.
  output logic                       counter_load,
  output logic [DATA_W-1:0]          program_fetch_counter,
  // Pipeline status toward fetch and decode.
  output logic                       issue_ready,
  output logic                       idle_insert,
  output logic [IDLE_CNT_W-1:0]      idle_remaining,
  output logic                       delay_slot_active,
  output logic                       target_arrive,
  output logic [DATA_W-1:0]          arrived_target,
  // Diagnostics.
  output logic                       illegal_unit,
  output logic                       idle_over_range,
  output logic                       issue_refused
);

  // Idle counter link.
  bwn_idle_if idle ();

  bwn_idle_counter u_idle_counter (
    .clock        (clock),
    .reset        (reset),
    .clock_enable (clock_enable),
    .idle         (idle.counter)
  );

  // Branch shadow state.
  typedef enum logic {
    BWN_ST_QUIET,
    BWN_ST_SHADOW
  } bwn_state_t;

  bwn_state_t           state;
  bwn_state_t           next_state;
  logic [DELAY_W-1:0]   delay_count;
  logic [DELAY_W-1:0]   next_delay_count;
  logic [DATA_W-1:0]    pending_target;
  logic [DATA_W-1:0]    next_pending_target;
  logic [DATA_W-1:0]    next_program_fetch_counter;
  logic [DATA_W-1:0]    next_arrived_target;
  logic                 next_counter_load;
  logic                 next_target_arrive;
  logic                 next_illegal_unit;
  logic                 next_idle_over_range;
  logic                 next_issue_refused;

  // Decode of the presented instruction.
  logic                 accept;
  logic                 is_idle_reg;
  logic                 is_idle_disp;
  logic                 is_nonneg;
  logic                 unit_ok;
  logic                 nonneg;
  logic                 taken;
  logic [DATA_W-1:0]    target;
  logic [DATA_W-1:0]    disp10;
  logic [DATA_W-1:0]    disp12;
  logic [IDLE_CNT_W-1:0] idle_base;
  logic                 shadow_ends;

  // Issue is refused while idle cycles are being inserted; the core is stalled then.
  assign issue_ready  = !idle.busy;
  assign accept       = issue_valid && issue_ready;
  assign is_idle_reg  = (issue_op == BWN_OP_IDLE_REG);
  assign is_idle_disp = (issue_op == BWN_OP_IDLE_DISP);
  assign is_nonneg    = (issue_op == BWN_OP_NONNEG);

  // Register form is only legal on the second S unit; elsewhere it only raises illegal_unit.
  assign unit_ok = !is_idle_reg || (issue_unit == BWN_UNIT_S2);

  // Sign bit test of any general register, not only a predicate register.
  assign nonneg = !tested_register[DATA_W-1];

  // Offsets are sign extended and scaled to words before the base is added.
  assign disp10 = {{(DATA_W-OFF10_W-OFF_SHIFT){signed_offset_immediate[OFF10_W-1]}},
                   signed_offset_immediate, {OFF_SHIFT{1'b0}}};
  assign disp12 = {{(DATA_W-OFF12_W-OFF_SHIFT){wide_signed_offset_immediate[OFF12_W-1]}},
                   wide_signed_offset_immediate, {OFF_SHIFT{1'b0}}};

  always_comb
  begin
    target = fetch_packet_base_address;
    unique case (issue_op)
      BWN_OP_IDLE_REG:  target = second_source_operand;
      BWN_OP_IDLE_DISP: target = fetch_packet_base_address + disp12;
      BWN_OP_NONNEG:    target = fetch_packet_base_address + disp10;
      BWN_OP_NONE:      target = fetch_packet_base_address;
    endcase
  end

  // The predicate gates only the branch; the nonnegative test is ANDed with it.
  always_comb
  begin
    taken = 1'b0;
    if (accept && unit_ok)
    begin
      unique case (issue_op)
        BWN_OP_IDLE_REG:  taken = predicate_true;
        BWN_OP_IDLE_DISP: taken = predicate_true;
        BWN_OP_NONNEG:    taken = predicate_true && nonneg;
        BWN_OP_NONE:      taken = 1'b0;
      endcase
    end
  end

  // Idle length: the count when taken, one more when not; the immediate is not clipped.
  always_comb
  begin
    idle_base = {1'b0, idle_count_immediate};
    idle.load_count = taken ? idle_base : (idle_base + IDLE_EXTRA);
    idle.load = accept && unit_ok && (is_idle_reg || is_idle_disp) &&
                (taken || (idle.load_count != IDLE_ZERO));
  end

  // The landing branch ends any idle run still going, so at most five cycles remain.
  assign shadow_ends = (state == BWN_ST_SHADOW) && (delay_count == DELAY_LAST);
  assign idle.cut    = shadow_ends;

  // Next values of the shadow tracker and the registered outputs.
  always_comb
  begin
    next_state                 = state;
    next_delay_count           = delay_count;
    next_pending_target        = pending_target;
    next_program_fetch_counter = program_fetch_counter;
    next_arrived_target        = arrived_target;
    next_counter_load          = 1'b0;
    next_target_arrive         = 1'b0;
    next_illegal_unit          = accept && !unit_ok;
    next_idle_over_range       = accept && unit_ok && (is_idle_reg || is_idle_disp) &&
                                 (idle_count_immediate > MAX_IDLE_IMM);
    next_issue_refused         = issue_valid && !issue_ready;

    unique case (state)
      BWN_ST_QUIET:
      begin
        next_delay_count = DELAY_ZERO;
      end
      BWN_ST_SHADOW:
      begin
        next_delay_count = delay_count - DELAY_LAST;
        if (shadow_ends)
        begin
          next_state          = BWN_ST_QUIET;
          next_target_arrive  = 1'b1;
          next_arrived_target = pending_target;
        end
      end
    endcase

    // A branch in the shadow of another restarts the shadow; two at once are not legal code.
    if (taken)
    begin
      next_state                 = BWN_ST_SHADOW;
      next_delay_count           = DELAY_SLOTS;
      next_pending_target        = target;
      next_program_fetch_counter = target;
      next_counter_load          = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state                 <= BWN_ST_QUIET;
      delay_count           <= DELAY_ZERO;
      pending_target        <= COUNTER_RESET;
      program_fetch_counter <= COUNTER_RESET;
      arrived_target        <= COUNTER_RESET;
      counter_load          <= 1'b0;
      target_arrive         <= 1'b0;
      illegal_unit          <= 1'b0;
      idle_over_range       <= 1'b0;
      issue_refused         <= 1'b0;
    end
    else if (clock_enable)
    begin
      state                 <= next_state;
      delay_count           <= next_delay_count;
      pending_target        <= next_pending_target;
      program_fetch_counter <= next_program_fetch_counter;
      arrived_target        <= next_arrived_target;
      counter_load          <= next_counter_load;
      target_arrive         <= next_target_arrive;
      illegal_unit          <= next_illegal_unit;
      idle_over_range       <= next_idle_over_range;
      issue_refused         <= next_issue_refused;
    end
  end

  // Status straight from the counter and shadow registers.
  assign idle_insert       = idle.busy;
  assign idle_remaining    = idle.count;
  assign delay_slot_active = (state == BWN_ST_SHADOW);

endmodule

`default_nettype wire

// ===== testbench/bwn_branch_sva.sv
// Concurrent checks on the ports of the branch unit.
`timescale 1ns/1ps
`default_nettype none
module bwn_branch_sva
  import bwn_pkg::*;
(
  // Control and instruction inputs, and the fetch counter output.
  input wire logic              clock, reset, clock_enable, issue_valid, predicate_true,
  input wire bwn_op_t           issue_op,
  input wire bwn_unit_t         issue_unit,
  input wire logic [DATA_W-1:0] second_source_operand, tested_register,
  input wire logic [DATA_W-1:0] fetch_packet_base_address, program_fetch_counter,
  input wire logic [2:0]        idle_count_immediate,
  input wire logic [9:0]        signed_offset_immediate,
  // Unit outputs.
  input wire logic [3:0]        idle_remaining,
  input wire logic              counter_load, issue_ready, idle_insert, target_arrive,
  input wire logic              illegal_unit, idle_over_range
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  wire acc = clock_enable && issue_valid && issue_ready;
  wire rg = acc && issue_op == BWN_OP_IDLE_REG && issue_unit == BWN_UNIT_S2;
  wire nn = acc && issue_op == BWN_OP_NONNEG;
  wire go = predicate_true && (rg || (nn && !tested_register[31]));
  wire [31:0] rel = fetch_packet_base_address
                  + {{20{signed_offset_immediate[9]}}, signed_offset_immediate, 2'b00};
  a_reg_target: assert property (rg && predicate_true |=> counter_load &&
    program_fetch_counter == $past(second_source_operand)) else $error("register target");
  a_s1_ignored: assert property (acc && issue_op == BWN_OP_IDLE_REG &&
    issue_unit == BWN_UNIT_S1 |=> illegal_unit && !counter_load && !idle_insert)
    else $error("S1 register branch acted");
  a_nonneg_target: assert property (nn && go |=> counter_load &&
    program_fetch_counter == $past(rel)) else $error("relative target");
  a_nonneg_skip: assert property (nn && !go |=> !counter_load && !idle_insert)
    else $error("nonnegative branch acted");
  a_false_count: assert property (rg && !predicate_true |=>
    !counter_load && idle_insert &&
    idle_remaining == {1'b0, $past(idle_count_immediate)} + 4'h1) else $error("false count");
  a_true_count: assert property (rg && predicate_true |=>
    idle_remaining == {1'b0, $past(idle_count_immediate)} &&
    idle_insert == ($past(idle_count_immediate) != 3'h0)) else $error("true count");
  a_over_flag: assert property (rg && idle_count_immediate > 3'h5 |=> idle_over_range)
    else $error("over-range not flagged");
  a_arrive_six: assert property (go ##1 (clock_enable && !issue_valid)[*5] |=>
    target_arrive) else $error("target late");
  a_taken_cut: assert property (rg && predicate_true && idle_count_immediate > 3'h5
    ##1 clock_enable[*5] |=> !idle_insert) else $error("idle not cut");
  c_taken: cover property (go);
  c_false_long: cover property (rg && !predicate_true && idle_count_immediate == 3'h7);
  c_negative: cover property (nn && tested_register[31]);
endmodule
bind bwn_branch_unit bwn_branch_sva chk (.clock, .reset, .clock_enable, .issue_valid,
  .predicate_true, .issue_op, .issue_unit, .second_source_operand, .tested_register,
  .fetch_packet_base_address, .program_fetch_counter, .idle_count_immediate,
  .signed_offset_immediate, .idle_remaining, .counter_load, .issue_ready, .idle_insert,
  .target_arrive, .illegal_unit, .idle_over_range);
`default_nettype wire

// ===== testbench/bwn_issue_model.sv
// Decode-side model that presents one instruction and holds it until it is taken.
`timescale 1ns/1ps
`default_nettype none
module bwn_issue_model (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic reset,
  // Bench request and unit handshake.
  input  wire logic start,
  input  wire logic clock_enable,
  input  wire logic issue_ready,
  output logic      issue_valid,
  output logic      took
);
  initial
  begin
    issue_valid = 1'b0;
    took = 1'b0;
  end
  // A single issue port means two taken branches can never share a packet.
  always @(posedge clock)
  begin
    took <= !reset && issue_valid && issue_ready && clock_enable;
  end
  always @(negedge clock)
  begin
    issue_valid <= !reset && (start || (issue_valid && !took));
  end
endmodule
`default_nettype wire

// ===== testbench/branch_with_nop_unit_test.sv
// Scenario testbench for the branch unit.
`timescale 1ns/1ps
`default_nettype none
module branch_with_nop_unit_test;
  import bwn_pkg::*;
  logic        clock = 1'b0, reset = 1'b1, clock_enable = 1'b1, start = 1'b0, p_in = 1'b0;
  logic        issue_valid, took, counter_load, ready, idle, arrive, ill, over, refused, shadow;
  bwn_op_t     op = BWN_OP_NONE;
  bwn_unit_t   unit = BWN_UNIT_S2;
  logic [31:0] src = 32'h0, base = 32'h0100_0500, fetch_ctr, arr;
  logic [2:0]  imm = 3'h0;
  logic [9:0]  off10 = 10'h0;
  logic [11:0] off12 = 12'hffc;
  logic [3:0]  rem;
  int          num_errors = 0, checked = 0, n_ref = 0;
  bwn_branch_unit dut (.clock, .reset, .clock_enable, .issue_valid, .issue_op(op),
    .issue_unit(unit), .predicate_true(p_in), .second_source_operand(src),
    .tested_register(src), .idle_count_immediate(imm), .signed_offset_immediate(off10),
    .wide_signed_offset_immediate(off12), .fetch_packet_base_address(base), .counter_load,
    .program_fetch_counter(fetch_ctr), .issue_ready(ready), .idle_insert(idle),
    .idle_remaining(rem), .delay_slot_active(shadow), .target_arrive(arrive),
    .arrived_target(arr), .illegal_unit(ill), .idle_over_range(over),
    .issue_refused(refused));
  bwn_issue_model part (.clock, .reset, .start, .clock_enable, .issue_ready(ready),
    .issue_valid, .took);
  initial forever #4 clock = ~clock;
  always @(negedge clock) if (refused === 1'b1) n_ref++;
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic send(input bwn_op_t o, input bwn_unit_t u, input logic p,
                      input logic [2:0] n, input logic [31:0] v);
    @(negedge clock);
    op = o;
    unit = u;
    p_in = p;
    imm = n;
    src = v;
    @(posedge clock) start <= 1'b1;
    @(posedge clock) start <= 1'b0;
    for (int k = 0; k < 20 && took !== 1'b1; k++) @(negedge clock);
    chk(took === 1'b1, "issue not taken");
  endtask
  task automatic watch(output int ni, output int at);
    ni = 0;
    at = 0;
    for (int k = 1; k <= 12; k++)
    begin
      if (idle === 1'b1) ni++;
      if (arrive === 1'b1) at = k;
      @(negedge clock);
    end
  endtask
  task automatic sc_idle();
    logic [2:0] n [7] = '{3'h2, 3'h7, 3'h7, 3'h0, 3'h0, 3'h5, 3'h1};
    logic p [7] = '{1, 1, 0, 0, 1, 1, 1};
    int e [7] = '{2, 5, 8, 1, 0, 5, 1};
    int ni, at;
    logic [31:0] t;
    for (int i = 0; i < 7; i++)
    begin
      t = (i == 6) ? 32'h0100_04f0 : 32'h0100_f000 + i;
      send(i == 6 ? BWN_OP_IDLE_DISP : BWN_OP_IDLE_REG, BWN_UNIT_S2, p[i], n[i],
           32'h0100_f000 + i);
      chk(counter_load === p[i] && (!p[i] || fetch_ctr === t), "target");
      chk(shadow === p[i], "shadow not opened");
      chk(over === (n[i] > 3'h5), "over-range flag");
      watch(ni, at);
      chk(ni == e[i], "idle cycle count");
      chk(at == (p[i] ? 6 : 0), "arrival slot");
      chk(shadow === 1'b0 && (!p[i] || arr === t), "arrived target");
    end
  endtask
  task automatic sc_s1();
    int ni, at;
    send(BWN_OP_IDLE_REG, BWN_UNIT_S1, 1'b1, 3'h2, 32'h40);
    chk(ill === 1'b1 && counter_load === 1'b0, "S1 register branch acted");
    watch(ni, at);
    chk(ni == 0 && at == 0, "S1 branch left traces");
    send(BWN_OP_NONE, BWN_UNIT_S2, 1'b1, 3'h4, 32'h44);
    chk({counter_load, idle, over, ill} === 4'h0, "empty slot acted");
  endtask
  task automatic sc_nonneg();
    logic [31:0] v [4] = '{32'h0, 32'h7fff_ffff, 32'h8000_0000, 32'h5};
    logic p [4] = '{1, 1, 1, 0};
    int ni, at;
    off10 = 10'h200;
    for (int i = 0; i < 4; i++)
    begin
      send(BWN_OP_NONNEG, BWN_UNIT_S1, p[i], 3'h3, v[i]);
      chk(counter_load === (i < 2), "relative branch");
      chk(i > 1 || fetch_ctr === 32'h00ff_fd00, "relative target");
      watch(ni, at);
      chk(ni == 0 && at == (i < 2 ? 6 : 0), "idle or arrival");
    end
  endtask
  task automatic sc_busy();
    int r0;
    r0 = n_ref;
    send(BWN_OP_IDLE_REG, BWN_UNIT_S2, 1'b1, 3'h3, 32'h80);
    send(BWN_OP_IDLE_REG, BWN_UNIT_S2, 1'b1, 3'h0, 32'h90);
    chk(n_ref > r0 && fetch_ctr === 32'h90, "issue during idle not held off");
  endtask
  task automatic sc_freeze();
    int k;
    send(BWN_OP_NONNEG, BWN_UNIT_S2, 1'b1, 3'h0, 32'h0);
    clock_enable = 1'b0;
    repeat (3) @(negedge clock);
    clock_enable = 1'b1;
    for (k = 4; k < 20 && arrive !== 1'b1; k++) @(negedge clock);
    chk(k == 9, "frozen cycles not added to shadow");
  endtask
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(negedge clock);
    reset = 1'b0;
    sc_idle();
    sc_s1();
    sc_nonneg();
    sc_busy();
    sc_freeze();
    give_verdict();
  end
  // The scenarios need a few hundred cycles, so this limit only trips on a hang.
  initial
  begin
    #40000;
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
